// ---- rtl/ssp_exec.sv ----
// executor for no-op, push, pop, double pop and shadow instructions
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - both no-op forms, upper byte all zeros or all ones, only advance the program counter in one cycle.
// - a file-register pop lowers the stack pointer by two and copies the new top word to the file register.
// - the file-register pop address is a word-aligned fifteen-bit word address in the lower 32K words.
// - a working-register pop lowers the stack pointer by two, unless it writes register fifteen, and writes the top word to the destination in any mode.
// - a double pop loads the odd register, then the even one, over two cycles, net decrement four unless the pair holds register fifteen.
// - the double pop names an even destination pair by a three-bit field.
// - a shadow pop restores registers zero to three and five status flags in one cycle.
// - the shadow store is one level deep and reached only by shadow push and pop.
// - a shadow pop leaves the shadow store unchanged.
// - a file-register push writes the word at the stack pointer and then raises it by two.
// - the file-register push address is word aligned and within the lower 32K words.
// - a working-register push moves any source mode into the post-incremented stack pointer location.
// - a shadow push copies registers zero to three and five status flags into the shadow store.
module ssp_exec
    import ssp_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [INSTR_W-1:0] instr,
    input wire logic instr_valid,
    output logic instr_ready,
    output logic [DATA_W-1:0] rd_addr,
    output logic rd_en,
    input wire logic [DATA_W-1:0] rd_data,
    output logic [DATA_W-1:0] wr_addr,
    output logic wr_en,
    output logic [DATA_W-1:0] wr_data,
    output logic [PC_W-1:0] pc_q,
    output logic [FLAGS_W-1:0] flags_q,
    output logic [DATA_W-1:0] stack_pointer_reg,
    output logic unknown_q
);

    // ***************************************************************
    // state
    // ***************************************************************
    typedef enum {ST_IDLE, ST_POP_D_LOW} ssp_state_type;

    ssp_state_type state_q, state_d;
    logic [2:0] pair_q, pair_d;
    logic [PC_W-1:0] pc_d;
    logic [FLAGS_W-1:0] flags_d;
    logic unknown_d;
    logic [SHADOW_REGS*DATA_W-1:0] shadow_w_q, shadow_w_d;
    logic [FLAGS_W-1:0] shadow_f_q, shadow_f_d;

    ssp_op_type op;
    logic take;
    logic [REG_IDX_W-1:0] rd_a_idx;
    logic [DATA_W-1:0] rd_a_data;
    logic [DATA_W-1:0] rd_b_data;
    logic [SHADOW_REGS*DATA_W-1:0] low_regs;
    logic reg_we;
    logic [REG_IDX_W-1:0] reg_idx;
    logic [DATA_W-1:0] reg_data;
    logic sp_we;
    logic [DATA_W-1:0] sp_data;
    logic restore_en;
    logic [DATA_W-1:0] sp_dec;
    logic [DATA_W-1:0] sp_inc;
    logic [2*DATA_W-1:0] ea;

    assign op = ssp_decode(instr);
    assign instr_ready = (state_q == ST_IDLE);
    assign take = instr_valid && instr_ready;
    assign sp_dec = stack_pointer_reg - WORD_STEP;
    assign sp_inc = stack_pointer_reg + WORD_STEP;
    assign rd_a_idx = (op == OP_PUSH_W) ? instr[3:0] : instr[10:7];

    ssp_work_regs u_regs (
        .clk(clk),
        .nrst(nrst),
        .rd_a_idx(rd_a_idx),
        .rd_a_data(rd_a_data),
        .rd_b_idx(instr[18:15]),
        .rd_b_data(rd_b_data),
        .stack_pointer_reg(stack_pointer_reg),
        .low_regs(low_regs),
        .wr_en(reg_we),
        .wr_idx(reg_idx),
        .wr_data(reg_data),
        .sp_we(sp_we),
        .sp_data(sp_data),
        .restore_en(restore_en),
        .restore_data(shadow_w_q)
    );

    // ***************************************************************
    // execute
    // ***************************************************************
    always_comb
    begin
        state_d = state_q;
        pair_d = pair_q;
        pc_d = pc_q;
        flags_d = flags_q;
        unknown_d = 1'b0;
        shadow_w_d = shadow_w_q;
        shadow_f_d = shadow_f_q;
        rd_addr = '0;
        rd_en = 1'b0;
        wr_addr = '0;
        wr_en = 1'b0;
        wr_data = '0;
        reg_we = 1'b0;
        reg_idx = '0;
        reg_data = '0;
        sp_we = 1'b0;
        sp_data = stack_pointer_reg;
        restore_en = 1'b0;
        ea = '0;
        case (state_q)
            ST_IDLE:
            begin
                if (take)
                begin
                    pc_d = pc_q + PC_STEP;
                    case (op)
                        OP_NOP:
                        begin
                            pc_d = pc_q + PC_STEP;
                        end
                        OP_POP_F:
                        begin
                            rd_addr = sp_dec;
                            rd_en = 1'b1;
                            wr_addr = {instr[15:1], 1'b0};
                            wr_en = 1'b1;
                            wr_data = rd_data;
                            sp_we = 1'b1;
                            sp_data = sp_dec;
                        end
                        OP_PUSH_F:
                        begin
                            rd_addr = {instr[15:1], 1'b0};
                            rd_en = 1'b1;
                            wr_addr = stack_pointer_reg;
                            wr_en = 1'b1;
                            wr_data = rd_data;
                            sp_we = 1'b1;
                            sp_data = sp_inc;
                        end
                        OP_POP_W:
                        begin
                            // source is the pre-decremented pointer
                            rd_addr = sp_dec;
                            rd_en = 1'b1;
                            sp_we = 1'b1;
                            sp_data = sp_dec;
                            ea = ssp_ea(instr[13:11], rd_a_data, rd_b_data);
                            if (instr[13:11] == MODE_DIRECT)
                            begin
                                reg_we = 1'b1;
                                reg_idx = instr[10:7];
                                reg_data = rd_data;
                            end
                            else
                            begin
                                wr_addr = ea[2*DATA_W-1:DATA_W];
                                wr_en = 1'b1;
                                wr_data = rd_data;
                                reg_we = ssp_mode_updates(instr[13:11]);
                                reg_idx = instr[10:7];
                                reg_data = ea[DATA_W-1:0];
                            end
                        end
                        OP_PUSH_W:
                        begin
                            ea = ssp_ea(instr[6:4], rd_a_data, rd_b_data);
                            wr_addr = stack_pointer_reg;
                            wr_en = 1'b1;
                            sp_we = 1'b1;
                            sp_data = sp_inc;
                            if (instr[6:4] == MODE_DIRECT)
                            begin
                                wr_data = rd_a_data;
                            end
                            else
                            begin
                                rd_addr = ea[2*DATA_W-1:DATA_W];
                                rd_en = 1'b1;
                                wr_data = rd_data;
                                reg_we = ssp_mode_updates(instr[6:4]);
                                reg_idx = instr[3:0];
                                reg_data = ea[DATA_W-1:0];
                            end
                        end
                        OP_POP_D:
                        begin
                            // upper word first, into the odd partner
                            rd_addr = sp_dec;
                            rd_en = 1'b1;
                            reg_we = 1'b1;
                            reg_idx = {instr[10:8], 1'b1};
                            reg_data = rd_data;
                            sp_we = 1'b1;
                            sp_data = sp_dec;
                            pair_d = instr[10:8];
                            state_d = ST_POP_D_LOW;
                        end
                        OP_POP_S:
                        begin
                            restore_en = 1'b1;
                            flags_d = shadow_f_q;
                            shadow_w_d = shadow_w_q;
                        end
                        OP_PUSH_S:
                        begin
                            // only path into the single-level store
                            shadow_w_d = low_regs;
                            shadow_f_d = flags_q;
                        end
                        default:
                        begin
                            unknown_d = 1'b1;
                        end
                    endcase
                end
            end
            ST_POP_D_LOW:
            begin
                rd_addr = sp_dec;
                rd_en = 1'b1;
                reg_we = 1'b1;
                reg_idx = {pair_q, 1'b0};
                reg_data = rd_data;
                sp_we = 1'b1;
                sp_data = sp_dec;
                state_d = ST_IDLE;
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            state_q <= ST_IDLE;
            pair_q <= 3'h0;
            pc_q <= PC_RESET;
            flags_q <= FLAGS_RESET;
            unknown_q <= 1'b0;
            shadow_w_q <= '0;
            shadow_f_q <= FLAGS_RESET;
        end
        else
        begin
            state_q <= state_d;
            pair_q <= pair_d;
            pc_q <= pc_d;
            flags_q <= flags_d;
            unknown_q <= unknown_d;
            shadow_w_q <= shadow_w_d;
            shadow_f_q <= shadow_f_d;
        end
    end

endmodule
`default_nettype wire

// ---- rtl/ssp_pkg.sv ----
// constants, types and helpers for the stack push/pop/no-op executor
package ssp_pkg;

    localparam int unsigned INSTR_W = 24;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned NUM_REGS = 16;
    localparam int unsigned REG_IDX_W = 4;
    localparam int unsigned FLAGS_W = 5;
    localparam int unsigned SHADOW_REGS = 4;
    localparam int unsigned PC_W = 24;

    localparam logic [REG_IDX_W-1:0] SP_IDX = 4'hF;
    localparam logic [DATA_W-1:0] WORD_STEP = 16'h0002;
    localparam logic [PC_W-1:0] PC_STEP = 24'h000002;
    localparam logic [PC_W-1:0] PC_RESET = 24'h000000;
    localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
    localparam logic [FLAGS_W-1:0] FLAGS_RESET = 5'h00;

    // status flag positions inside the five-bit flag vector
    localparam int unsigned FLAG_C = 0;
    localparam int unsigned FLAG_Z = 1;
    localparam int unsigned FLAG_OV = 2;
    localparam int unsigned FLAG_N = 3;
    localparam int unsigned FLAG_DC = 4;

    // opcode fields
    localparam logic [7:0] OPC_NOP = 8'h00;
    localparam logic [7:0] OPC_ALT_NOP = 8'hFF;
    localparam logic [7:0] OPC_POP_F = 8'hF9;
    localparam logic [7:0] OPC_PUSH_F = 8'hF8;
    localparam logic [4:0] OPC_MOVE = 5'h0F;
    localparam logic [6:0] MOVE_POP_SRC = 7'h4F;
    localparam logic [6:0] MOVE_PUSH_DST = 7'h3F;
    localparam logic [INSTR_W-1:0] OPC_POP_S = 24'hFE8000;
    localparam logic [INSTR_W-1:0] OPC_PUSH_S = 24'hFEA000;
    localparam logic [INSTR_W-1:0] POP_D_MASK = 24'hFFF8FF;
    localparam logic [INSTR_W-1:0] POP_D_CODE = 24'hBE004F;

    // addressing modes of the three-bit mode fields
    localparam logic [2:0] MODE_DIRECT = 3'h0;
    localparam logic [2:0] MODE_IND = 3'h1;
    localparam logic [2:0] MODE_POST_DEC = 3'h2;
    localparam logic [2:0] MODE_POST_INC = 3'h3;
    localparam logic [2:0] MODE_PRE_DEC = 3'h4;
    localparam logic [2:0] MODE_PRE_INC = 3'h5;

    typedef enum {
        OP_NOP,
        OP_POP_F,
        OP_PUSH_F,
        OP_POP_W,
        OP_PUSH_W,
        OP_POP_D,
        OP_POP_S,
        OP_PUSH_S,
        OP_OTHER
    } ssp_op_type;

    function automatic ssp_op_type ssp_decode(input logic [INSTR_W-1:0] i);
        ssp_op_type op;
        op = OP_OTHER;
        if (i[23:16] == OPC_NOP || i[23:16] == OPC_ALT_NOP)
            op = OP_NOP;
        else if (i[23:16] == OPC_POP_F && !i[0])
            op = OP_POP_F;
        else if (i[23:16] == OPC_PUSH_F && !i[0])
            op = OP_PUSH_F;
        else if (i[23:19] == OPC_MOVE && !i[14] && i[6:0] == MOVE_POP_SRC)
            op = OP_POP_W;
        else if (i[23:19] == OPC_MOVE && !i[14] && i[13:7] == MOVE_PUSH_DST)
            op = OP_PUSH_W;
        else if ((i & POP_D_MASK) == POP_D_CODE)
            op = OP_POP_D;
        else if (i == OPC_POP_S)
            op = OP_POP_S;
        else if (i == OPC_PUSH_S)
            op = OP_PUSH_S;
        return op;
    endfunction

    // true when the mode writes the pointer register back
    function automatic logic ssp_mode_updates(input logic [2:0] mode);
        return mode == MODE_POST_DEC || mode == MODE_POST_INC ||
               mode == MODE_PRE_DEC || mode == MODE_PRE_INC;
    endfunction

    // effective address in the upper half, updated pointer in the lower
    function automatic logic [2*DATA_W-1:0] ssp_ea(
        input logic [2:0] mode,
        input logic [DATA_W-1:0] ptr,
        input logic [DATA_W-1:0] offs
    );
        logic [DATA_W-1:0] addr;
        logic [DATA_W-1:0] upd;
        addr = ptr;
        upd = ptr;
        case (mode)
            MODE_POST_DEC: upd = ptr - WORD_STEP;
            MODE_POST_INC: upd = ptr + WORD_STEP;
            MODE_PRE_DEC:
            begin
                addr = ptr - WORD_STEP;
                upd = addr;
            end
            MODE_PRE_INC:
            begin
                addr = ptr + WORD_STEP;
                upd = addr;
            end
            MODE_DIRECT, MODE_IND: addr = ptr;
            default: addr = ptr + offs;
        endcase
        return {addr, upd};
    endfunction

endpackage

// ---- rtl/ssp_work_regs.sv ----
// working register file with stack pointer port and shadow restore
`timescale 1ns/1ps
`default_nettype none
module ssp_work_regs
    import ssp_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [REG_IDX_W-1:0] rd_a_idx,
    output logic [DATA_W-1:0] rd_a_data,
    input wire logic [REG_IDX_W-1:0] rd_b_idx,
    output logic [DATA_W-1:0] rd_b_data,
    output logic [DATA_W-1:0] stack_pointer_reg,
    output logic [SHADOW_REGS*DATA_W-1:0] low_regs,
    input wire logic wr_en,
    input wire logic [REG_IDX_W-1:0] wr_idx,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic sp_we,
    input wire logic [DATA_W-1:0] sp_data,
    input wire logic restore_en,
    input wire logic [SHADOW_REGS*DATA_W-1:0] restore_data
);

    logic [DATA_W-1:0] regs_q [NUM_REGS];
    logic [DATA_W-1:0] regs_d [NUM_REGS];

    always_comb
    begin
        for (int k = 0; k < NUM_REGS; k++)
        begin
            regs_d[k] = regs_q[k];
        end
        if (sp_we)
        begin
            regs_d[SP_IDX] = sp_data;
        end
        // the general write port wins over the pointer port
        if (wr_en)
        begin
            regs_d[wr_idx] = wr_data;
        end
        if (restore_en)
        begin
            for (int k = 0; k < SHADOW_REGS; k++)
            begin
                regs_d[k] = restore_data[k*DATA_W +: DATA_W];
            end
        end
        // stack pointer stays word aligned
        regs_d[SP_IDX][0] = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        for (int k = 0; k < NUM_REGS; k++)
        begin
            if (!nrst)
                regs_q[k] <= REG_RESET;
            else
                regs_q[k] <= regs_d[k];
        end
    end

    assign rd_a_data = regs_q[rd_a_idx];
    assign rd_b_data = regs_q[rd_b_idx];
    assign stack_pointer_reg = regs_q[SP_IDX];

    genvar g;
    generate
        for (g = 0; g < SHADOW_REGS; g++)
        begin : g_low
            assign low_regs[g*DATA_W +: DATA_W] = regs_q[g];
        end
    endgenerate

endmodule
`default_nettype wire

// ---- bench/ssp_exec_props.sv ----
// port checker for the stack push/pop/no-op executor
`timescale 1ns/1ps
`default_nettype none
module ssp_exec_checker
    import ssp_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [INSTR_W-1:0] instr,
    input wire logic instr_valid,
    input wire logic instr_ready,
    input wire logic [DATA_W-1:0] rd_addr,
    input wire logic rd_en,
    input wire logic [DATA_W-1:0] rd_data,
    input wire logic [DATA_W-1:0] wr_addr,
    input wire logic wr_en,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic [PC_W-1:0] pc_q,
    input wire logic [FLAGS_W-1:0] flags_q,
    input wire logic [DATA_W-1:0] stack_pointer_reg,
    input wire logic unknown_q
);
    // ****************************************
    // decode of the watched instruction forms
    // ****************************************
    wire logic tk = instr_valid && instr_ready;
    wire logic is_nop = instr[23:16] == 8'h00 || instr[23:16] == 8'hFF;
    wire logic pop_f = instr[23:16] == 8'hF9 && !instr[0];
    wire logic push_f = instr[23:16] == 8'hF8 && !instr[0];
    wire logic mov = instr[23:19] == 5'h0F && !instr[14];
    // direct forms only, pointer writes to the stack pointer excluded
    wire logic pop_w = mov && instr[6:0] == 7'h4F && instr[13:11] == 3'h0
        && instr[10:7] != 4'hF;
    wire logic push_w = mov && instr[13:7] == 7'h3F && instr[6:4] == 3'h0;
    wire logic pop_d = (instr & 24'hFFF8FF) == 24'hBE004F;
    wire logic shadow = instr == 24'hFE8000 || instr == 24'hFEA000;
    wire logic [DATA_W-1:0] sp_dn = stack_pointer_reg - 16'h0002;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_nop_pc_step: assert property (
        tk && is_nop |=> pc_q == $past(pc_q) + 24'h000002
            && $stable(stack_pointer_reg)
    ) else $error("no-op did not only step the pc");
    a_nop_no_write: assert property (
        tk && is_nop |-> !wr_en
    ) else $error("no-op wrote memory");
    a_popf_access: assert property (
        tk && pop_f |-> rd_en && rd_addr == sp_dn && wr_en
            && wr_addr == {instr[15:1], 1'b0} && wr_data == rd_data
    ) else $error("file pop access wrong");
    a_popf_sp_down: assert property (
        tk && pop_f |=> stack_pointer_reg == $past(sp_dn)
    ) else $error("file pop pointer wrong");
    a_pushf_access: assert property (
        tk && push_f |-> rd_en && rd_addr == instr[15:0] && wr_en
            && wr_addr == stack_pointer_reg && wr_data == rd_data
    ) else $error("file push access wrong");
    a_pushf_sp_up: assert property (
        tk && push_f |=>
            stack_pointer_reg == $past(stack_pointer_reg) + 16'h0002
    ) else $error("file push pointer wrong");
    a_popw_direct: assert property (
        tk && pop_w |-> rd_en && rd_addr == sp_dn && !wr_en
            ##1 stack_pointer_reg == $past(sp_dn)
    ) else $error("register pop wrong");
    a_pushw_direct: assert property (
        tk && push_w |-> wr_en && wr_addr == stack_pointer_reg
            ##1 stack_pointer_reg == $past(stack_pointer_reg) + 16'h0002
    ) else $error("register push wrong");
    a_popd_two_cycles: assert property (
        tk && pop_d |-> rd_en && rd_addr == sp_dn
            ##1 !instr_ready && rd_en && rd_addr == sp_dn
            ##1 instr_ready && stack_pointer_reg
                == $past(stack_pointer_reg, 2) - 16'h0004
    ) else $error("double pop sequence wrong");
    a_flags_held: assert property (
        !(tk && instr == 24'hFE8000) |=> $stable(flags_q)
    ) else $error("flags changed outside shadow pop");
    a_shadow_no_mem: assert property (
        tk && shadow |-> !wr_en
    ) else $error("shadow access touched memory");
    a_byte_move_unknown: assert property (
        tk && instr[23:19] == 5'h0F && instr[14] |=> unknown_q
    ) else $error("byte move was executed as a stack move");
endmodule
bind ssp_exec ssp_exec_checker u_chk (.clk(clk), .nrst(nrst),
    .instr(instr), .instr_valid(instr_valid), .instr_ready(instr_ready),
    .rd_addr(rd_addr), .rd_en(rd_en), .rd_data(rd_data),
    .wr_addr(wr_addr), .wr_en(wr_en), .wr_data(wr_data), .pc_q(pc_q),
    .flags_q(flags_q), .stack_pointer_reg(stack_pointer_reg),
    .unknown_q(unknown_q));
`default_nettype wire

// ---- bench/ssp_mem_model.sv ----
// data memory model holding the software stack
`timescale 1ns/1ps
`default_nettype none
module ssp_mem_model
    import ssp_pkg::*;
(
    input wire logic clk,
    input wire logic rd_en,
    input wire logic [DATA_W-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data,
    input wire logic wr_en,
    input wire logic [DATA_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data
);
    // word array of the lower 32K words, byte bit ignored
    logic [DATA_W-1:0] mem [0:32767];
    logic [DATA_W-1:0] last_q = 16'h0000;
    // idle read bus shows the inverse so stale data never matches
    assign rd_data = rd_en ? mem[rd_addr[15:1]] : ~last_q;
    always @(posedge clk)
    begin
        if (wr_en)
            mem[wr_addr[15:1]] <= wr_data;
        if (rd_en)
            last_q <= rd_data;
    end
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// self-checking bench for the stack push/pop/no-op executor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [23:0] instr = 24'h000000;
    logic instr_valid = 1'b0;
    wire logic instr_ready, rd_en, wr_en, unknown_q;
    wire logic [15:0] rd_addr, rd_data, wr_addr, wr_data, stack_pointer_reg;
    wire logic [23:0] pc_q;
    wire logic [4:0] flags_q;
    int err_total = 0;
    int total_checks = 0;
    logic [15:0] exp_sp = 16'h0000;
    logic [15:0] exp_pc = 16'h0000;

    always #10 clk = ~clk;

    ssp_exec DUT (.clk(clk), .nrst(nrst), .instr(instr),
        .instr_valid(instr_valid), .instr_ready(instr_ready),
        .rd_addr(rd_addr), .rd_en(rd_en), .rd_data(rd_data),
        .wr_addr(wr_addr), .wr_en(wr_en), .wr_data(wr_data), .pc_q(pc_q),
        .flags_q(flags_q), .stack_pointer_reg(stack_pointer_reg),
        .unknown_q(unknown_q));
    ssp_mem_model mem_i (.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_data(rd_data), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data));

    // ****************************************
    // shared helpers
    // ****************************************
    task automatic print_verdict();
        if (err_total == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp,
        input string what);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t ns: %s got %h expected %h",
                $time, what, got, exp);
        end
    endtask

    task automatic poke(input logic [15:0] a, input logic [15:0] v);
        mem_i.mem[a[15:1]] = v;
    endtask

    function automatic logic [15:0] peek(input logic [15:0] a);
        return mem_i.mem[a[15:1]];
    endfunction

    // leaves valid up; caller changes or drops it before the next edge
    task automatic exec(input logic [23:0] i, input logic [15:0] d);
        int n;
        n = 0;
        instr <= i;
        instr_valid <= 1'b1;
        while (instr_ready !== 1'b1)
        begin
            @(negedge clk);
            n++;
            if (n > 4)
            begin
                err_total++;
                $display("wrong value at %0t ns: never taken", $time);
                print_verdict();
            end
        end
        @(negedge clk);
        exp_pc += 16'h0002;
        exp_sp += d;
        check(pc_q[15:0], exp_pc, "pc");
        check(stack_pointer_reg, exp_sp, "sp");
        check({11'h000, flags_q}, 16'h0000, "flags");
    endtask

    task automatic stop();
        instr_valid <= 1'b0;
        @(negedge clk);
    endtask

    task automatic set_w(input logic [3:0] r, input logic [15:0] v);
        poke(exp_sp - 16'h0002, v);
        exec(24'h78004F | {13'h0000, r, 7'h00}, 16'hFFFE);
    endtask

    task automatic get_w(input logic [3:0] r, input logic [15:0] v);
        exec(24'h781F80 | {20'h00000, r}, 16'h0002);
        check(peek(exp_sp - 16'h0002), v, "pushed word");
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic s_nop();
        exec(24'h000000, 16'h0000);
        exec(24'hFF5AA5, 16'h0000);
        exec(24'h00FFFF, 16'h0000);
        exec(24'hFFFFFF, 16'h0000);
        stop();
    endtask

    task automatic s_file();
        poke(16'h1230, 16'hA401);
        poke(16'h0880, 16'h67AA);
        exec(24'hF81230, 16'h0002);
        check(peek(16'h0000), 16'hA401, "push f");
        exec(24'hF80880, 16'h0002);
        exec(24'hF9FFFE, 16'hFFFE);
        check(peek(16'hFFFE), 16'h67AA, "pop f top");
        exec(24'hF90002, 16'hFFFE);
        check(peek(16'h0002), 16'hA401, "pop f");
        stop();
    endtask

    task automatic s_work();
        repeat (4) exec(24'hF80880, 16'h0002);
        set_w(4'h5, 16'h0900);
        poke(exp_sp - 16'h0002, 16'hC45A);
        exec(24'h780ACF, 16'hFFFE);
        check(peek(16'h0900), 16'hC45A, "pop to [w]");
        exec(24'h781F95, 16'h0002);
        check(peek(exp_sp - 16'h0002), 16'hC45A, "push [w]");
        poke(exp_sp - 16'h0002, 16'h1111);
        exec(24'h781ACF, 16'hFFFE);
        check(peek(16'h0900), 16'h1111, "pop to [w++]");
        get_w(4'h5, 16'h0902);
        stop();
    endtask

    task automatic s_double();
        poke(exp_sp - 16'h0002, 16'h7654);
        poke(exp_sp - 16'h0004, 16'h3210);
        exec(24'hBE034F, 16'hFFFE);
        check({15'h0000, instr_ready}, 16'h0000, "stall");
        @(negedge clk);
        exp_sp -= 16'h0002;
        check(stack_pointer_reg, exp_sp, "double pop sp");
        check({15'h0000, instr_ready}, 16'h0001, "ready");
        get_w(4'h7, 16'h7654);
        get_w(4'h6, 16'h3210);
        stop();
    endtask

    task automatic s_shadow();
        for (int i = 0; i < 4; i++)
            set_w(i[3:0], 16'h5A00 + 16'(i));
        exec(24'hFEA000, 16'h0000);
        for (int i = 0; i < 4; i++)
            get_w(i[3:0], 16'h5A00 + 16'(i));
        for (int i = 0; i < 4; i++)
            set_w(i[3:0], 16'h00F0);
        exec(24'hFE8000, 16'h0000);
        for (int i = 0; i < 4; i++)
            get_w(i[3:0], 16'h5A00 + 16'(i));
        set_w(4'h0, 16'hDEAD);
        exec(24'hFE8000, 16'h0000);
        get_w(4'h0, 16'h5A00);
        stop();
    endtask

    task automatic s_odd();
        exec(24'h123456, 16'h0000);
        check({15'h0000, unknown_q}, 16'h0001, "unknown flag");
        // byte-mode move is not a stack operation
        exec(24'h7842CF, 16'h0000);
        check({15'h0000, unknown_q}, 16'h0001, "byte move");
        stop();
        check({15'h0000, unknown_q}, 16'h0000, "unknown pulse");
    endtask

    task automatic s_reset();
        nrst <= 1'b0;
        repeat (2) @(negedge clk);
        nrst <= 1'b1;
        exp_pc = 16'h0000;
        exp_sp = 16'h0000;
        check(pc_q[15:0], 16'h0000, "pc after reset");
        check(stack_pointer_reg, 16'h0000, "sp after reset");
        // shadow must come back cleared, not the value loaded here
        set_w(4'h0, 16'hBEEF);
        exec(24'hFE8000, 16'h0000);
        get_w(4'h0, 16'h0000);
        stop();
    endtask

    initial
    begin
        repeat (16) @(negedge clk);
        nrst <= 1'b1;
        s_nop();
        s_file();
        s_work();
        s_double();
        s_shadow();
        s_odd();
        s_reset();
        print_verdict();
    end
endmodule
`default_nettype wire
